// [scan_port_defs.svh]
// constants for the test access port: instructions, widths, lengths
`ifndef SCAN_PORT_DEFS_SVH
`define SCAN_PORT_DEFS_SVH
`define IR_WIDTH        4
`define INSTR_EXTEST    4'h0
`define INSTR_SAMPLE    4'h2
`define INSTR_IDCODE    4'h1
`define INSTR_ISPENTER  4'h8
`define INSTR_ISPWRITE  4'h9
`define INSTR_ISPEXIT   4'ha
`define INSTR_BYPASS    4'hf
`define IR_CAPTURE      4'h1
`define ID_WIDTH        32
`define ID_DEFAULT      32'h1234_5001
`define PROG_WIDTH      32
`define PROG_ERASED     32'hffff_ffff
`endif

// [scan_port_pkg.sv]
// types shared by the test access port design
package scan_port_pkg;
  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR,
    EXIT2_DR, UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR,
    EXIT2_IR, UPD_IR
  } tap_state_e;
endpackage

// [pin_scan_cell.sv]
// one boundary cell: capture stages in the chain plus update stages
`timescale 1ns/1ps
module pin_scan_cell (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic captureEn,
  input  wire logic shiftEn,
  input  wire logic updateEn,
  input  wire logic isMacrocell,
  input  wire logic serialIn,
  input  wire logic pinIn,
  input  wire logic coreOut,
  input  wire logic coreOe,
  output logic      serialOut,
  output logic      updData_q,
  output logic      updOe_q
);
  logic capIn_q;
  logic capOut_q;
  logic capOe_q;

  // three capture stages chained oe -> out -> in
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      capIn_q  <= 1'b0;
      capOut_q <= 1'b0;
      capOe_q  <= 1'b0;
    end else if (captureEn) begin
      capIn_q  <= pinIn;
      capOut_q <= coreOut;
      capOe_q  <= isMacrocell ? 1'b0 : coreOe;
    end else if (shiftEn) begin
      capOe_q  <= serialIn;
      capOut_q <= capOe_q;
      capIn_q  <= capOut_q;
    end
  end
  assign serialOut = capIn_q;

  // update stages; macrocell cells keep only the data stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      updData_q <= 1'b0;
      updOe_q   <= 1'b0;
    end else if (updateEn) begin
      updData_q <= capOut_q;
      updOe_q   <= isMacrocell ? 1'b0 : capOe_q;
    end
  end
endmodule // pin_scan_cell

// [scan_tap_port.sv]
// test access port with boundary chain, id, bypass and programming path
//
// Behaviour
// [RULE_01] There is no test reset pin; the controller enters its reset state at power-up reset.
// [RULE_02] The port decodes sample/preload, extest, bypass and idcode instructions.
// [RULE_03] Every input and I/O pin owns its own boundary cell.
// [RULE_04] The chain length follows the bonded count of up to 96 I/O and four inputs.
// [RULE_05] Each cell has three capture stages and up to two update stages.
// [RULE_06] Pin cells and macrocell cells are two variants of the cell.
// [RULE_07] Cells chain through their capture stages from tdi to tdo.
// [RULE_08] Capture stages sample signals, shift serially and load update stages.
// [RULE_09] Capture, shift and update strobes are made inside by the controller.
// [RULE_10] The part is programmed through the four port pins with a scan-style sequence.
// [RULE_11] When the port option is off the four pins are ordinary user I/O.
// [RULE_12] An interrupted programming run locks the part and floats all pins. The code still drives tdo in the shift states while locked.
// [RULE_13] With the keeper option pins hold their last driven level during programming.
// [RULE_14] The programming store comes out of reset erased.
// [RULE_15] The controller walks the sixteen-state machine on test clock rising edges.
// [RULE_16] Bypass selects a one-bit register and idcode a 32-bit register.
`timescale 1ns/1ps
`include "scan_port_defs.svh"
module scan_tap_port
  import scan_port_pkg::*;
#(
  parameter int NUM_IO    = 96,
  parameter int NUM_IN    = 4,
  parameter int NUM_MC    = 8,
  parameter logic [31:0] ID_CODE = `ID_DEFAULT // arbitrary value
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 portEnable,
  input  wire logic                 keeperEnable,
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdoOe,
  input  wire logic [3:0]           portPinIn,
  output logic [3:0]                portPinOut,
  output logic [3:0]                portPinOe,
  input  wire logic [3:0]           userPortOut,
  input  wire logic [3:0]           userPortOe,
  output logic [3:0]                userPortIn,
  input  wire logic [NUM_IO-1:0]    ioPinIn,
  output logic [NUM_IO-1:0]         ioPinOut,
  output logic [NUM_IO-1:0]         ioPinOe,
  input  wire logic [NUM_IO-1:0]    coreIoOut,
  input  wire logic [NUM_IO-1:0]    coreIoOe,
  input  wire logic [NUM_IN-1:0]    inPin,
  input  wire logic [NUM_MC-1:0]    macroOut,
  output logic [NUM_IO+NUM_IN-1:0]  coreIn,
  output logic                      progLocked,
  output logic [`PROG_WIDTH-1:0]    progData
);
  localparam int CHAIN = NUM_IO + NUM_IN + NUM_MC;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [7:0] pinSync1_q;
  logic [7:0] pinSync2_q;
  logic       tckLast_q;
  logic [NUM_IO+NUM_IN-1:0] bndSync1_q;
  logic [NUM_IO+NUM_IN-1:0] bndSync2_q;
  wire  [3:0] portRaw = {tck, tms, tdi, 1'b0};
  // test clock only counts while the port option is on
  wire tckS   = pinSync2_q[3] & portEnable;
  wire tmsS   = pinSync2_q[2];
  wire tdiS   = pinSync2_q[1];

  // two flops on test pins, user pins and boundary pins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinSync1_q <= 8'h0;
      pinSync2_q <= 8'h0;
      tckLast_q  <= 1'b0;
      bndSync1_q <= '0;
      bndSync2_q <= '0;
    end else begin
      pinSync1_q <= {portPinIn, portRaw};
      pinSync2_q <= pinSync1_q;
      tckLast_q  <= tckS;
      bndSync1_q <= {inPin, ioPinIn};
      bndSync2_q <= bndSync1_q;
    end
  end
  wire tckRise = tckS & ~tckLast_q; // RULE_15
  wire tckFall = ~tckS & tckLast_q;

  // ---------------------------------------------------------------
  // controller state machine
  // ---------------------------------------------------------------
  tap_state_e state_q;
  tap_state_e state_d;

  // next state from tms
  always_comb begin
    state_d = state_q;
    case (state_q)
      TEST_RESET: state_d = tmsS ? TEST_RESET : RUN_IDLE;
      RUN_IDLE:   state_d = tmsS ? SEL_DR : RUN_IDLE;
      SEL_DR:     state_d = tmsS ? SEL_IR : CAP_DR;
      CAP_DR:     state_d = tmsS ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:   state_d = tmsS ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:   state_d = tmsS ? UPD_DR : PAUSE_DR;
      PAUSE_DR:   state_d = tmsS ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:   state_d = tmsS ? UPD_DR : SHIFT_DR;
      UPD_DR:     state_d = tmsS ? SEL_DR : RUN_IDLE;
      SEL_IR:     state_d = tmsS ? TEST_RESET : CAP_IR;
      CAP_IR:     state_d = tmsS ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:   state_d = tmsS ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:   state_d = tmsS ? UPD_IR : PAUSE_IR;
      PAUSE_IR:   state_d = tmsS ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:   state_d = tmsS ? UPD_IR : SHIFT_IR;
      UPD_IR:     state_d = tmsS ? SEL_DR : RUN_IDLE;
      default:    state_d = TEST_RESET;
    endcase
  end

  // reset is the power-up reset, no test reset pin
  always_ff @(posedge clk) begin
    if (!reset_n) state_q <= TEST_RESET; // RULE_01
    else if (tckRise) state_q <= state_d; // RULE_15
  end

  // ---------------------------------------------------------------
  // strobes and instruction decode
  // ---------------------------------------------------------------
  wire capDr   = tckRise & (state_q == CAP_DR); // RULE_09
  wire shDr    = tckRise & (state_q == SHIFT_DR);
  wire updDr   = tckRise & (state_q == UPD_DR);
  wire capIr   = tckRise & (state_q == CAP_IR);
  wire shIr    = tckRise & (state_q == SHIFT_IR);
  wire updIr   = tckRise & (state_q == UPD_IR);

  logic [`IR_WIDTH-1:0] irShift_q;
  logic [`IR_WIDTH-1:0] ir_q;
  wire selExtest = (ir_q == `INSTR_EXTEST); // RULE_02
  wire selSample = (ir_q == `INSTR_SAMPLE);
  wire selId     = (ir_q == `INSTR_IDCODE);
  wire selPwr    = (ir_q == `INSTR_ISPWRITE);
  wire selBound  = selExtest | selSample;
  wire selBypass = ~(selBound | selId | selPwr); // RULE_16

  // instruction register, idcode after reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irShift_q <= '0;
      ir_q      <= `INSTR_IDCODE;
    end else if (state_q == TEST_RESET) begin
      ir_q      <= `INSTR_IDCODE;
    end else if (capIr) begin
      irShift_q <= `IR_CAPTURE;
    end else if (shIr) begin
      irShift_q <= {tdiS, irShift_q[`IR_WIDTH-1:1]};
    end else if (updIr) begin
      ir_q      <= irShift_q;
    end
  end

  // ---------------------------------------------------------------
  // bypass, id and programming data registers
  // ---------------------------------------------------------------
  logic                   bypass_q;
  logic [`ID_WIDTH-1:0]   id_q;
  logic [`PROG_WIDTH-1:0] progShift_q;
  logic                   inProg_q;
  logic                   progDone_q;

  // bypass and id shift paths
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bypass_q <= 1'b0;
      id_q     <= '0;
    end else begin
      if (capDr & selBypass) bypass_q <= 1'b0; // RULE_16
      else if (shDr & selBypass) bypass_q <= tdiS;
      if (capDr & selId) id_q <= ID_CODE; // RULE_16
      else if (shDr & selId) id_q <= {tdiS, id_q[`ID_WIDTH-1:1]};
    end
  end

  // programming store starts erased, enter/exit bracket a run
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      progShift_q <= '0;
      progData    <= `PROG_ERASED; // RULE_14
      inProg_q    <= 1'b0;
      progDone_q  <= 1'b1;
    end else begin
      if (shDr & selPwr) progShift_q <= {tdiS, progShift_q[`PROG_WIDTH-1:1]};
      if (updDr & selPwr) progData <= progShift_q; // RULE_10
      if (updIr & (irShift_q == `INSTR_ISPENTER)) begin
        inProg_q   <= 1'b1;
        progDone_q <= 1'b0;
      end else if (updIr & (irShift_q == `INSTR_ISPEXIT)) begin
        inProg_q   <= 1'b0;
        progDone_q <= 1'b1;
      end else if (state_q == TEST_RESET) begin
        inProg_q   <= 1'b0; // abandoned run leaves progDone_q low
      end
    end
  end
  // locked when a run began and was never closed
  assign progLocked = ~progDone_q & ~inProg_q; // RULE_12

  // ---------------------------------------------------------------
  // boundary chain
  // ---------------------------------------------------------------
  logic [CHAIN:0]   chain;
  logic [CHAIN-1:0] updData;
  logic [CHAIN-1:0] updOe;
  wire  [CHAIN-1:0] cellPin  = {macroOut, bndSync2_q};
  wire  [CHAIN-1:0] cellCore = {macroOut, {NUM_IN{1'b0}}, coreIoOut};
  wire  [CHAIN-1:0] cellOe   = {{NUM_MC + NUM_IN{1'b0}}, coreIoOe};
  assign chain[0] = tdiS; // RULE_07

  // one cell per pin, macrocell variant past the pins
  for (genvar i = 0; i < CHAIN; i++) begin : g_cell // RULE_03 RULE_04
    pin_scan_cell u_cell (
      .clk         (clk),
      .reset_n     (reset_n),
      .captureEn   (capDr & selBound), // RULE_08
      .shiftEn     (shDr & selBound),
      .updateEn    (updDr & selBound),
      .isMacrocell (i >= NUM_IO + NUM_IN), // RULE_06
      .serialIn    (chain[i]),
      .pinIn       (cellPin[i]),
      .coreOut     (cellCore[i]),
      .coreOe      (cellOe[i]),
      .serialOut   (chain[i+1]), // RULE_05
      .updData_q   (updData[i]),
      .updOe_q     (updOe[i])
    );
  end

  // ---------------------------------------------------------------
  // pin muxing and tdo
  // ---------------------------------------------------------------
  logic [NUM_IO-1:0] keepVal_q;
  wire holdPins = inProg_q & keeperEnable; // RULE_13

  // remember last driven level for the keeper
  always_ff @(posedge clk) begin
    if (!reset_n) keepVal_q <= '0;
    else if (!inProg_q) keepVal_q <= ioPinOut;
  end

  assign ioPinOut = holdPins ? keepVal_q :
                    selExtest ? updData[NUM_IO-1:0] : coreIoOut;
  assign ioPinOe  = progLocked ? '0 : holdPins ? '1 : // RULE_12
                    selExtest ? updOe[NUM_IO-1:0] : coreIoOe;
  assign coreIn   = progLocked ? '0 : bndSync2_q;

  logic tdo_q;
  logic tdoOe_q;
  wire  shiftNow = (state_q == SHIFT_DR) | (state_q == SHIFT_IR);
  wire  tdoSel   = (state_q == SHIFT_IR) ? irShift_q[0] :
                   selBound ? chain[CHAIN] : selId ? id_q[0] :
                   selPwr ? progShift_q[0] : bypass_q;

  // tdo changes on falling test clock
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tdo_q   <= 1'b0;
      tdoOe_q <= 1'b0;
    end else if (tckFall) begin
      tdo_q   <= tdoSel;
      tdoOe_q <= shiftNow;
    end
  end
  assign tdo   = tdo_q;
  assign tdoOe = tdoOe_q & portEnable;

  // port pins are user I/O when the port option is off
  assign portPinOut = portEnable ? 4'h0 : userPortOut; // RULE_11
  assign portPinOe  = (portEnable | progLocked) ? 4'h0 : userPortOe;
  assign userPortIn = portEnable ? 4'h0 : pinSync2_q[7:4]; // RULE_11
endmodule // scan_tap_port

// [scan_tap_checker.sv]
// concurrent checks on the pins of the test access port
`timescale 1ns/1ps
`include "scan_port_defs.svh"
module scan_tap_checker #(
  parameter int NUM_IO = 96,
  parameter int NUM_IN = 4
) (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic                    portEnable,
  input wire logic                    tdo,
  input wire logic                    tdoOe,
  input wire logic [3:0]              portPinOut,
  input wire logic [3:0]              portPinOe,
  input wire logic [3:0]              userPortOut,
  input wire logic [3:0]              userPortOe,
  input wire logic [3:0]              userPortIn,
  input wire logic [NUM_IO-1:0]       ioPinOe,
  input wire logic [NUM_IO+NUM_IN-1:0] coreIn,
  input wire logic                    progLocked,
  input wire logic [31:0]             progData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // pin and reset relations
  // ---------------------------------------------------------------
  a_lock_floats: assert property (
    progLocked |-> ioPinOe == '0) else $error("pin driven while locked");
  a_lock_core_zero: assert property (
    progLocked [*3] |-> coreIn == '0) else $error("core sees locked pins");
  a_user_pin_drive: assert property (
    !portEnable && !progLocked |-> portPinOut == userPortOut
    && portPinOe == userPortOe) else $error("user drive not passed");
  a_user_in_quiet: assert property (
    portEnable [*2] |-> userPortIn == 4'h0) else $error("user input live");
  a_tdo_oe_off: assert property (
    !portEnable |-> !tdoOe) else $error("tdo driven with port off");
  a_prog_frozen: assert property (
    !portEnable [*4] |=> $stable(progData)) else $error("store moved");
  a_reset_erased: assert property (disable iff (1'b0)
    !reset_n |=> progData == `PROG_ERASED && !progLocked)
    else $error("store not erased by reset");
  a_reset_tdo_off: assert property (disable iff (1'b0)
    !reset_n |=> !tdo && !tdoOe) else $error("tdo active in reset");
  c_locked: cover property ($rose(progLocked));
  c_shift: cover property (tdoOe [*4]);
  c_user: cover property (!portEnable [*3]);
endmodule // scan_tap_checker

bind scan_tap_port scan_tap_checker #(.NUM_IO(NUM_IO), .NUM_IN(NUM_IN))
  scan_tap_checker_i (.clk(clk), .reset_n(reset_n),
  .portEnable(portEnable), .tdo(tdo), .tdoOe(tdoOe),
  .portPinOut(portPinOut), .portPinOe(portPinOe),
  .userPortOut(userPortOut), .userPortOe(userPortOe),
  .userPortIn(userPortIn), .ioPinOe(ioPinOe), .coreIn(coreIn),
  .progLocked(progLocked), .progData(progData));

// [scan_tester.sv]
// behavioural tester driving tck, tms and tdi and reading tdo
`timescale 1ns/1ps
module scan_tester (
  input  wire logic clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one test clock of 200 ns; tdo taken just before the next fall
  task automatic step(input logic m, input logic d, output logic q);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(negedge clk);
    tck <= 1'b1;
    repeat (4) @(negedge clk);
    q = tdo;
  endtask
  // move state only; data line toggles as it is not looked at
  task automatic tick(input logic m);
    logic q;
    step(m, ~tdi, q);
  endtask
  // five highs reach test-reset from anywhere, then idle
  task automatic reset_tap();
    repeat (5) tick(1'b1);
    tick(1'b0);
  endtask
  // idle to idle through one scan of n bits, lsb first
  task automatic scan(input logic ir, input logic [31:0] din,
                      input int n, output logic [31:0] dout);
    logic q;
    dout = '0;
    tick(1'b1);
    if (ir) tick(1'b1);
    tick(1'b0);
    tick(1'b0);
    for (int k = 0; k < n; k++) begin
      step(k == n - 1, din[k], q);
      dout[k] = q;
    end
    tick(1'b1);
    tick(1'b0);
  endtask
endmodule // scan_tester

// [testbench.sv]
// self-checking bench for the test access port
`timescale 1ns/1ps
`include "scan_port_defs.svh"
module testbench;
  localparam int NIO = 2;
  localparam int NIN = 4;
  localparam int CH = 3 * (NIO + NIN + 2);
  localparam logic [31:0] ID = 32'h5a3c_0e01; // arbitrary value
  logic              clk, reset_n, portEnable, keeperEnable;
  logic              tck, tms, tdi, tdo, tdoOe, progLocked;
  logic [3:0]        portPinIn, portPinOut, portPinOe;
  logic [3:0]        userPortOut, userPortOe, userPortIn;
  logic [NIO-1:0]    ioPinIn, ioPinOut, ioPinOe, coreIoOut, coreIoOe;
  logic [NIN-1:0]    inPin;
  logic [1:0]        macroOut;
  logic [NIO+NIN-1:0] coreIn;
  logic [31:0]       progData, got, din, dout, seed;
  logic [31:0]       expQ[$];
  int                failures, cmpCount;
  event              gotEv;
  scan_tap_port #(.NUM_IO(NIO), .NUM_IN(NIN), .NUM_MC(2), .ID_CODE(ID))
    scan_tap_port_i (.clk(clk), .reset_n(reset_n), .portEnable(portEnable),
    .keeperEnable(keeperEnable), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoOe(tdoOe), .portPinIn(portPinIn),
    .portPinOut(portPinOut), .portPinOe(portPinOe),
    .userPortOut(userPortOut), .userPortOe(userPortOe),
    .userPortIn(userPortIn), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut),
    .ioPinOe(ioPinOe), .coreIoOut(coreIoOut), .coreIoOe(coreIoOe),
    .inPin(inPin), .macroOut(macroOut), .coreIn(coreIn),
    .progLocked(progLocked), .progData(progData));
  scan_tester scan_tester_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo));
  always #12.5 clk = ~clk;
  // ---------------------------------------------------------------
  // result queue and watcher
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] e, input logic [31:0] a);
    expQ.push_back(e);
    got = a;
    -> gotEv;
    @(negedge clk);
  endtask
  always @(gotEv) begin
    logic [31:0] e;
    e = expQ.pop_front();
    cmpCount++;
    if (got !== e) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, got);
    end
  end
  task automatic ir(input logic [3:0] code);
    scan_tester_i.scan(1'b1, 32'(code), 4, dout);
  endtask
  task automatic final_report();
    $display("compares=%0d mismatches=%0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = $urandom(91929);
    clk = 1'b0;
    reset_n = 1'b0;
    portEnable = 1'b1;
    keeperEnable = 1'b1;
    {portPinIn, userPortOut, userPortOe} = 12'($urandom);
    {ioPinIn, coreIoOut, coreIoOe} = 6'($urandom);
    {inPin, macroOut} = 6'($urandom);
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    check(`PROG_ERASED, progData);
    scan_tester_i.tick(1'b0);
    scan_tester_i.scan(1'b0, 32'h0, 32, dout);
    check(ID, dout);
    ir(`INSTR_IDCODE);
    check(32'(`IR_CAPTURE), dout);
    scan_tester_i.scan(1'b0, 32'h0, 32, dout);
    check(ID, dout);
    $display("test identity done");
    for (int c = 11; c < 16; c++) begin
      din = $urandom;
      ir(4'(c));
      scan_tester_i.scan(1'b0, din, 8, dout);
      check({24'h0, din[6:0], 1'b0}, dout);
    end
    $display("test bypass done");
    din = $urandom;
    ir(`INSTR_SAMPLE);
    scan_tester_i.scan(1'b0, din, 32, dout);
    check(din & ((32'h1 << (32 - CH)) - 1), dout >> CH);
    for (int c = 0; c < NIO; c++)
      check(32'(ioPinIn[c]), 32'(dout[CH-3-3*c]));
    ir(`INSTR_EXTEST);
    for (int c = 0; c < NIO; c++) begin
      check(32'(din[30-3*c]), 32'(ioPinOut[c]));
      check(32'(din[31-3*c]), 32'(ioPinOe[c]));
    end
    $display("test chain done");
    ir(`INSTR_ISPENTER);
    for (int c = 0; c < NIO; c++)
      check(32'(din[30-3*c]), 32'(ioPinOut[c]));
    check(32'({NIO{1'b1}}), 32'(ioPinOe));
    keeperEnable = 1'b0;
    @(negedge clk);
    check(32'(coreIoOut), 32'(ioPinOut));
    keeperEnable = 1'b1;
    din = $urandom;
    ir(`INSTR_ISPWRITE);
    scan_tester_i.scan(1'b0, din, 32, dout);
    ir(`INSTR_ISPEXIT);
    check(din, progData);
    ir(`INSTR_ISPENTER);
    scan_tester_i.reset_tap();
    check(32'h1, 32'(progLocked));
    check(32'h0, 32'(ioPinOe));
    ir(`INSTR_ISPEXIT);
    check(32'h0, 32'(progLocked));
    $display("test programming done");
    portEnable = 1'b0;
    {userPortOut, userPortOe} = 8'($urandom);
    repeat (4) @(negedge clk);
    check(32'(userPortOut), 32'(portPinOut));
    check(32'(userPortOe), 32'(portPinOe));
    check(32'(portPinIn), 32'(userPortIn));
    ir(`INSTR_ISPENTER);
    check(din, progData);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    check(`PROG_ERASED, progData);
    $display("test user pins done");
    final_report();
  end
  initial begin
    #500us;
    failures++;
    final_report();
  end
endmodule // testbench
